/* hw/adc_pp_pkg.sv */
`default_nettype none

package adc_pp_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 6;
  localparam logic [5:0] IDX_CTL_A = 6'h00;
  localparam logic [5:0] IDX_STAT2 = 6'h01;
  localparam logic [5:0] IDX_CTL_B = 6'h0a;
  localparam logic [5:0] IDX_RES_A = 6'h0b;
  localparam logic [5:0] IDX_RES_B = 6'h0c;
  localparam logic [5:0] IDX_AUX = 6'h10;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h11;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h12;

  //////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTL_DONE_BIT = 7;
  localparam int CTL_IRQ_EN_BIT = 6;
  localparam int CTL_CONT_BIT = 5;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 5;
  localparam int STAT2_ACTIVE_BIT = 7;
  localparam int STAT2_TRIG_BIT = 6;
  localparam int AUX_CMP_BIT = 0;

  //////////////////////////////////////////////////////////////////////////////
  // channel codes
  localparam logic [4:0] CHAN_LAST_INPUT = 5'h1b;
  localparam logic [4:0] CHAN_RESERVED = 5'h1c;
  localparam logic [4:0] CHAN_REF_HIGH = 5'h1d;
  localparam logic [4:0] CHAN_REF_LOW = 5'h1e;
  localparam logic [4:0] CHAN_OFF = 5'h1f;

  //////////////////////////////////////////////////////////////////////////////
  // reset values and bus codes
  localparam logic [4:0] CHAN_RST = 5'h1f;
  localparam logic [1:0] IRQ_MASK_RST = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // one paired control register
  typedef struct packed {
    logic done;
    logic irq_en;
    logic cont;
    logic [4:0] chan;
  } ctl_t;

  // command bundle towards the analog core
  typedef struct packed {
    logic start;
    logic abort;
    logic power;
    logic isolate;
    logic [4:0] chan;
  } conv_cmd_t;

  typedef enum logic {CONV_IDLE, CONV_BUSY} conv_state_t;

endpackage

`default_nettype wire

/* hw/adc_pingpong_control_regs.sv */
// Operation
// [RULE1] only one of the two control registers governs the converter at a time
// [RULE2] writing the other register never disturbs a running conversion
// [RULE3] writing the governing register aborts and restarts, unless channel is all ones; with trigger select one code aborts and waits for a trigger
// [RULE4] bits 15 to 8 of the control registers read zero, writes ignored
// [RULE5] compare off: done flag sets on every completed conversion
// [RULE6] compare on: done flag sets only when compare result is true
// [RULE7] done flag clears on control register write or result register read
// [RULE8] interrupt raised when done flag sets with interrupt enable high
// [RULE9] continuous off: one conversion per write or per hardware trigger
// [RULE10] continuous on: back to back conversions after write or trigger
// [RULE11] five bit channel code: inputs 0 to 27, reserved, high and low reference
// [RULE12] all ones channel turns converter off and isolates the input
// [RULE13] all ones channel stops continuous conversion with no extra conversion
// [RULE14] without continuous mode converter powers down after each conversion
// [RULE15] trigger select bit: zero software writes, one hardware trigger input
// [RULE16] active bit sets on start, clears on completion or abort
// [RULE17] interrupt stays while done flag and enable both set; code also drops it on a status write of one or a mask bit of zero
`timescale 1ns/1ps
`default_nettype none

module adc_pingpong_control_regs #(
  parameter int RESULT_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // trigger pin
  input wire logic hw_trigger_in,
  // analog core, same clock
  input wire logic conv_done,
  input wire logic [RESULT_W-1:0] conv_result,
  input wire logic compare_true,
  output adc_pp_pkg::conv_cmd_t conv_cmd,
  // interrupt
  output logic done_irq
);
  import adc_pp_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // control register image on the bus
  function automatic logic [31:0] ctl_pack(input ctl_t c);
    logic [31:0] r;
    r = 32'h0;
    r[CTL_DONE_BIT] = c.done;
    r[CTL_IRQ_EN_BIT] = c.irq_en;
    r[CTL_CONT_BIT] = c.cont;
    r[CHAN_LSB +: CHAN_W] = c.chan;
    return r;
  endfunction

  // written image; upper bits dropped, flag cleared by any write
  function automatic ctl_t ctl_unpack(input logic [31:0] w);
    ctl_t c;
    c.done = 1'b0;
    c.irq_en = w[CTL_IRQ_EN_BIT];
    c.cont = w[CTL_CONT_BIT];
    c.chan = w[CHAN_LSB +: CHAN_W];
    return c;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state

  ctl_t ctl_q [2];
  ctl_t ctl_d [2];
  logic [RESULT_W-1:0] res_q [2];
  logic [RESULT_W-1:0] res_d [2];
  conv_state_t state_q, state_d;
  logic gov_q, gov_d;
  logic trig_hw_q, trig_hw_d;
  logic cmp_en_q, cmp_en_d;
  logic [1:0] mask_q, mask_d;
  logic [1:0] irq_stat_q, irq_stat_d;
  logic irq_q, irq_d;
  conv_cmd_t cmd_q, cmd_d;
  logic wr_pend_q, wr_pend_d;
  logic [IDX_W-1:0] wr_idx_q, wr_idx_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic hreadyout_q;
  logic hresp_q;
  logic trig_s1_q, trig_s2_q, trig_s3_q;

  logic addr_ok;
  logic rd_now;
  logic [IDX_W-1:0] addr_idx;
  logic wr_sc;
  logic wr_sel;
  logic busy;
  logic trig_edge;
  logic start;
  logic restart;
  logic abort;
  logic [1:0] done_set;
  logic [1:0] ev_now;
  logic [1:0] ev_old;
  ctl_t wctl;

  //////////////////////////////////////////////////////////////////////////////
  // bus address phase decode

  // upper address bits are not decoded, so the map aliases
  always_comb begin
    addr_ok = hsel && hready && htrans[1];
    rd_now = addr_ok && !hwrite;
    addr_idx = haddr[IDX_LSB +: IDX_W];
    wr_sc = wr_pend_q && (wr_idx_q == IDX_CTL_A || wr_idx_q == IDX_CTL_B);
    wr_sel = (wr_idx_q == IDX_CTL_B);
    wctl = ctl_unpack(hwdata);
    busy = (state_q == CONV_BUSY);
    trig_edge = trig_s2_q && !trig_s3_q;
    wr_pend_d = addr_ok && hwrite;
    wr_idx_d = addr_idx;
  end

  //////////////////////////////////////////////////////////////////////////////
  // conversion sequencing and register updates

  always_comb begin
    ctl_d = ctl_q;
    res_d = res_q;
    state_d = state_q;
    gov_d = gov_q;
    trig_hw_d = trig_hw_q;
    cmp_en_d = cmp_en_q;
    mask_d = mask_q;
    start = 1'b0;
    restart = 1'b0;
    abort = 1'b0;
    done_set = 2'h0;

    // completion of the running conversion
    if (busy && conv_done) begin
      if (!cmp_en_q || compare_true) begin
        done_set[gov_q] = 1'b1; // RULE5 RULE6
      end
      res_d[gov_q] = conv_result;
      if (ctl_q[gov_q].cont && ctl_q[gov_q].chan != CHAN_OFF) begin // RULE13
        restart = 1'b1; // RULE10
      end else begin
        state_d = CONV_IDLE; // RULE9 RULE14 RULE16
        if (trig_hw_q) begin
          gov_d = ~gov_q; // RULE1
        end
      end
    end

    // control register writes
    if (wr_sc) begin
      ctl_d[wr_sel] = wctl; // RULE2 RULE4 RULE7
      if (wr_sel == gov_q) begin
        abort = busy; // RULE3 RULE16
        restart = 1'b0;
        state_d = CONV_IDLE;
        gov_d = gov_q;
        if (wctl.chan != CHAN_OFF && !trig_hw_q) begin
          start = 1'b1; // RULE3
        end
      end else if (state_d == CONV_IDLE && !restart && !trig_hw_q &&
                   wctl.chan != CHAN_OFF) begin
        // idle converter: the fresh register takes over
        gov_d = wr_sel; // RULE1
        start = 1'b1; // RULE9
      end
    end

    // hardware trigger, ignored while a conversion runs
    if (trig_hw_q && trig_edge && state_d == CONV_IDLE && !start &&
        ctl_d[gov_d].chan != CHAN_OFF) begin
      start = 1'b1; // RULE15 RULE9
    end

    // other registers
    if (wr_pend_q) begin
      case (wr_idx_q)
        IDX_STAT2: trig_hw_d = hwdata[STAT2_TRIG_BIT]; // RULE15
        IDX_AUX: cmp_en_d = hwdata[AUX_CMP_BIT];
        IDX_IRQ_MASK: mask_d = hwdata[1:0];
        default: ;
      endcase
    end

    // result read clears the matching flag; a set in that cycle wins
    if (rd_now && addr_idx == IDX_RES_A) begin
      ctl_d[0].done = 1'b0; // RULE7
    end
    if (rd_now && addr_idx == IDX_RES_B) begin
      ctl_d[1].done = 1'b0; // RULE7
    end
    for (int i = 0; i < 2; i++) begin
      if (done_set[i]) begin
        ctl_d[i].done = 1'b1;
      end
    end

    if (start || restart) begin
      state_d = CONV_BUSY; // RULE16
    end

    // command towards the analog core
    cmd_d.start = start || restart;
    cmd_d.abort = abort;
    cmd_d.power = (state_d == CONV_BUSY); // RULE14 RULE12
    cmd_d.isolate = (ctl_d[gov_d].chan == CHAN_OFF); // RULE12 RULE13
    cmd_d.chan = ctl_d[gov_d].chan; // RULE11
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt status, mask and output

  // status tracks flag and enable, so it also drops when either clears
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ev_now[i] = ctl_d[i].done && ctl_d[i].irq_en;
      ev_old[i] = ctl_q[i].done && ctl_q[i].irq_en;
    end
    irq_stat_d = irq_stat_q;
    if (wr_pend_q && wr_idx_q == IDX_IRQ_STAT) begin
      irq_stat_d = irq_stat_q & ~hwdata[1:0];
    end
    irq_stat_d = (irq_stat_d | (ev_now & ~ev_old)) & ev_now; // RULE8 RULE17
    irq_d = |(irq_stat_d & mask_d); // RULE8
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data, taken from next values so a read right behind a write is fresh

  always_comb begin
    hrdata_d = hrdata_q;
    if (rd_now) begin
      hrdata_d = 32'h0;
      case (addr_idx)
        IDX_CTL_A: hrdata_d = ctl_pack(ctl_d[0]); // RULE4
        IDX_CTL_B: hrdata_d = ctl_pack(ctl_d[1]); // RULE4
        IDX_STAT2: begin
          hrdata_d[STAT2_ACTIVE_BIT] = (state_d == CONV_BUSY); // RULE16
          hrdata_d[STAT2_TRIG_BIT] = trig_hw_d;
        end
        IDX_RES_A: hrdata_d[RESULT_W-1:0] = res_d[0];
        IDX_RES_B: hrdata_d[RESULT_W-1:0] = res_d[1];
        IDX_AUX: hrdata_d[AUX_CMP_BIT] = cmp_en_d;
        IDX_IRQ_STAT: hrdata_d[1:0] = irq_stat_d;
        IDX_IRQ_MASK: hrdata_d[1:0] = mask_d;
        default: hrdata_d = 32'h0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  // trigger pin synchroniser; only stage two and three feed the edge detect
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= hw_trigger_in;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  // control state; channel resets to off so the converter starts powered down
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 2; i++) begin
        ctl_q[i] <= '{done: 1'b0, irq_en: 1'b0, cont: 1'b0, chan: CHAN_RST};
        res_q[i] <= '0;
      end
      state_q <= CONV_IDLE;
      gov_q <= 1'b0;
      trig_hw_q <= 1'b0;
      cmp_en_q <= 1'b0;
      mask_q <= IRQ_MASK_RST;
      irq_stat_q <= 2'h0;
      irq_q <= 1'b0;
      cmd_q <= '{start: 1'b0, abort: 1'b0, power: 1'b0, isolate: 1'b1, chan: CHAN_RST};
    end else begin
      ctl_q <= ctl_d;
      res_q <= res_d;
      state_q <= state_d;
      gov_q <= gov_d;
      trig_hw_q <= trig_hw_d;
      cmp_en_q <= cmp_en_d;
      mask_q <= mask_d;
      irq_stat_q <= irq_stat_d;
      irq_q <= irq_d;
      cmd_q <= cmd_d;
    end
  end

  // bus side; zero wait states, always okay
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= '0;
      hrdata_q <= 32'h0;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_idx_q <= wr_idx_d;
      hrdata_q <= hrdata_d;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign conv_cmd = cmd_q;
  assign done_irq = irq_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  logic rd_sc_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_sc_q <= 1'b0;
    end else begin
      rd_sc_q <= rd_now && (addr_idx == IDX_CTL_A || addr_idx == IDX_CTL_B);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_start_gov_chan: assert property ( // RULE1
    cmd_q.start |-> cmd_q.chan == ctl_q[gov_q].chan)
    else $error("start channel differs from governing register");

  chk_nongov_quiet: assert property ( // RULE2
    (wr_sc && wr_sel != gov_q && busy && !conv_done) |=> !cmd_q.abort && busy)
    else $error("write to idle register disturbed conversion");

  chk_gov_abort: assert property ( // RULE3
    (wr_sc && wr_sel == gov_q && busy && wctl.chan != CHAN_OFF && !trig_hw_q)
    |=> cmd_q.abort && cmd_q.start && busy)
    else $error("governing write did not abort and restart");

  chk_rsvd_zero: assert property ( // RULE4
    rd_sc_q |-> hrdata_q[31:8] == 24'h0)
    else $error("reserved control bits read nonzero");

  chk_done_set: assert property ( // RULE5
    (busy && conv_done && !cmp_en_q) |=> ctl_q[$past(gov_q)].done)
    else $error("done flag not set after conversion");

  chk_cmp_gate: assert property ( // RULE6
    (busy && conv_done && cmp_en_q && !compare_true && !ctl_q[gov_q].done)
    |=> !ctl_q[$past(gov_q)].done)
    else $error("done flag set with false compare");

  chk_irq_cause: assert property ( // RULE17
    irq_q |-> $past((ctl_d[0].done && ctl_d[0].irq_en) ||
                    (ctl_d[1].done && ctl_d[1].irq_en)))
    else $error("interrupt without enabled done flag");

  chk_single_idle: assert property ( // RULE14
    (busy && conv_done && !ctl_q[gov_q].cont && !wr_pend_q)
    |=> !cmd_q.power ##1 !busy)
    else $error("converter stayed powered after single conversion");

  chk_off_code: assert property ( // RULE12
    (wr_sc && wr_sel == gov_q && wctl.chan == CHAN_OFF)
    |=> cmd_q.isolate && !cmd_q.power && !cmd_q.start)
    else $error("off code did not stop converter");

endmodule

`default_nettype wire

/* testbench/adc_pingpong_control_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module adc_pingpong_control_regs_tb_top;
  import adc_pp_pkg::*;

  logic clk;
  logic sys_rst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic hw_trigger_in;
  logic conv_done;
  logic [11:0] conv_result;
  logic compare_true;
  conv_cmd_t conv_cmd;
  logic done_irq;
  logic [31:0] rd;
  int n_fail = 0;
  int total_checks = 0;
  int n_start = 0;
  int n_abort = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // single slave, so its hreadyout is the bus hready
  adc_pingpong_control_regs #(.RESULT_W(12)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .hw_trigger_in(hw_trigger_in),
    .conv_done(conv_done), .conv_result(conv_result), .compare_true(compare_true),
    .conv_cmd(conv_cmd), .done_irq(done_irq)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // start and abort are one-cycle pulses, so counting them is easier than catching them
  always @(posedge clk) begin
    if (conv_cmd.start === 1'b1) n_start <= n_start + 1;
    if (conv_cmd.abort === 1'b1) n_abort <= n_abort + 1;
  end

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chkb(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask

  // address phase held until hready, then data phase held until hready again
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, idx, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  // registered outputs need two more edges after the cause lands
  task automatic settle;
    repeat (2) @(posedge clk);
  endtask

  task automatic pulse_done(input logic cmp);
    settle();
    compare_true <= cmp;
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    int s;
    s = n_start;
    rdchk(IDX_CTL_A, 32'h1f);
    rdchk(IDX_CTL_B, 32'h1f);
    chkb(conv_cmd.isolate, 1'b1);
    rdchk(IDX_IRQ_MASK, 32'h3);
    rdchk(6'h3f, 32'h0);
    wr(IDX_CTL_B, 32'hffff_ff7f);
    rdchk(IDX_CTL_B, 32'h7f);
    wr(IDX_CTL_B, 32'h1f);
    settle();
    chk(n_start, s);
    chkb(hresp, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_single;
    int s;
    s = n_start;
    wr(IDX_CTL_A, 32'h43);
    settle();
    chk(n_start, s + 1);
    chk(32'(conv_cmd.chan), 32'h3);
    chkb(conv_cmd.power, 1'b1);
    rdchk(IDX_STAT2, 32'h80);
    pulse_done(1'b0);
    rdchk(IDX_CTL_A, 32'hc3);
    chkb(conv_cmd.power, 1'b0);
    rdchk(IDX_STAT2, 32'h0);
    chkb(done_irq, 1'b1);
    wr(IDX_IRQ_MASK, 32'h0);
    settle();
    chkb(done_irq, 1'b0);
    wr(IDX_IRQ_MASK, 32'h3);
    settle();
    chkb(done_irq, 1'b1);
    wr(IDX_IRQ_STAT, 32'h3);
    settle();
    chkb(done_irq, 1'b0);
    wr(IDX_CTL_A, 32'h1f);
    rdchk(IDX_CTL_A, 32'h1f);
    $display("test single done");
  endtask

  task automatic t_abort;
    int s;
    int a;
    wr(IDX_CTL_A, 32'h04);
    settle();
    s = n_start;
    a = n_abort;
    wr(IDX_CTL_B, 32'h09);
    settle();
    chk(n_start, s);
    chk(n_abort, a);
    chk(32'(conv_cmd.chan), 32'h4);
    rdchk(IDX_CTL_B, 32'h09);
    wr(IDX_CTL_A, 32'h05);
    settle();
    chk(n_abort, a + 1);
    chk(n_start, s + 1);
    chk(32'(conv_cmd.chan), 32'h5);
    wr(IDX_CTL_A, 32'h1f);
    settle();
    chk(n_abort, a + 2);
    chk(n_start, s + 1);
    chkb(conv_cmd.isolate, 1'b1);
    chkb(conv_cmd.power, 1'b0);
    rdchk(IDX_STAT2, 32'h0);
    $display("test abort done");
  endtask

  task automatic t_cont;
    int s;
    s = n_start;
    wr(IDX_CTL_A, 32'h22);
    settle();
    chk(n_start, s + 1);
    pulse_done(1'b0);
    chk(n_start, s + 2);
    chkb(conv_cmd.power, 1'b1);
    pulse_done(1'b0);
    chk(n_start, s + 3);
    wr(IDX_CTL_A, 32'h1f);
    repeat (5) @(posedge clk);
    chk(n_start, s + 3);
    chkb(conv_cmd.power, 1'b0);
    $display("test continuous done");
  endtask

  task automatic t_compare;
    wr(IDX_AUX, 32'h1);
    wr(IDX_CTL_A, 32'h47);
    pulse_done(1'b0);
    rdchk(IDX_CTL_A, 32'h47);
    chkb(done_irq, 1'b0);
    wr(IDX_CTL_A, 32'h47);
    pulse_done(1'b1);
    rdchk(IDX_CTL_A, 32'hc7);
    chkb(done_irq, 1'b1);
    rdchk(IDX_RES_A, 32'h5a5);
    settle();
    rdchk(IDX_CTL_A, 32'h47);
    chkb(done_irq, 1'b0);
    wr(IDX_AUX, 32'h0);
    $display("test compare done");
  endtask

  task automatic t_chan;
    logic [4:0] codes[6];
    codes = '{5'h00, 5'h0e, 5'h1b, 5'h1c, 5'h1d, 5'h1e};
    foreach (codes[i]) begin
      wr(IDX_CTL_A, 32'(codes[i]));
      settle();
      chk(32'(conv_cmd.chan), 32'(codes[i]));
      chkb(conv_cmd.isolate, 1'b0);
      pulse_done(1'b0);
    end
    $display("test channels done");
  endtask

  // last, because a finished hardware conversion hands control to the other register
  task automatic t_hw;
    int s;
    wr(IDX_STAT2, 32'h40);
    rdchk(IDX_STAT2, 32'h40);
    s = n_start;
    // in trigger mode a write to the idle register is only stored
    wr(IDX_CTL_B, 32'h09);
    wr(IDX_CTL_A, 32'h08);
    repeat (4) @(posedge clk);
    chk(n_start, s);
    hw_trigger_in <= 1'b1;
    repeat (6) @(posedge clk);
    chk(n_start, s + 1);
    chk(32'(conv_cmd.chan), 32'h8);
    hw_trigger_in <= 1'b0;
    pulse_done(1'b0);
    repeat (4) @(posedge clk);
    chk(n_start, s + 1);
    chkb(conv_cmd.power, 1'b0);
    // next trigger must run on the other register
    hw_trigger_in <= 1'b1;
    repeat (6) @(posedge clk);
    chk(n_start, s + 2);
    chk(32'(conv_cmd.chan), 32'h9);
    hw_trigger_in <= 1'b0;
    pulse_done(1'b0);
    rdchk(IDX_CTL_B, 32'h89);
    rdchk(IDX_RES_B, 32'h5a5);
    rdchk(IDX_CTL_B, 32'h09);
    wr(IDX_STAT2, 32'h0);
    $display("test hardware trigger done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hw_trigger_in = 1'b0;
    conv_done = 1'b0;
    conv_result = 12'h5a5;
    compare_true = 1'b0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_single();
    t_abort();
    t_cont();
    t_compare();
    t_chan();
    t_hw();
    complete_run();
  end

endmodule

`default_nettype wire
